// File: hdl/ms_delay.sv
// Millisecond delay counter that restarts when its start level drops
`timescale 1ns/100ps
module ms_delay (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic msTick,
   input wire logic start,
   input wire logic [9:0] limit,
   output logic done
);
   logic [9:0] count_q; // Ticks seen since start
   logic done_q; // Limit reached

   // Count ticks while started, clear at once when start is lost
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         count_q <= 10'h000;
         done_q <= 1'b0;
      end else if (!start) begin
         count_q <= 10'h000; // see R18
         done_q <= 1'b0;
      end else begin
         if (msTick && !done_q) begin
            count_q <= count_q + 10'h001;
         end
         done_q <= (count_q >= limit);
      end
   end

   assign done = done_q;
endmodule

// File: hdl/sync2.sv
// Two-flop synchroniser for asynchronous input levels
`timescale 1ns/100ps
module sync2 #(
   parameter int WIDTH = 1
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] meta_q; // First stage, read only by second
   logic [WIDTH-1:0] stable_q; // Second stage

   // Shift the levels through two flops
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_q <= '0;
         stable_q <= '0;
      end else begin
         meta_q <= asyncIn;
         stable_q <= meta_q;
      end
   end

   assign syncOut = stable_q;
endmodule

// File: hdl/wake_and_power_good_sequencer.sv
// Keyboard/mouse wake pulse, resume reset and power-good sequencing
`timescale 1ns/100ps
module wake_and_power_good_sequencer #(
   parameter int TICK_CYCLES = wake_power_pkg::TICK_CYCLES,
   parameter logic [9:0] PULSE_MS = wake_power_pkg::WAKE_PULSE_MS
) (
   input wire logic core_clk,
   input wire logic reset_n,
   // Avalon-MM slave
   input wire logic [9:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Keyboard and mouse event inputs
   input wire logic [7:0] kbdByte,
   input wire logic kbdByteValid,
   input wire logic mouseLeftClick,
   input wire logic mouseRightClick,
   input wire logic mouseMove,
   // Supply and panel pins
   input wire logic standbySupplyValid,
   input wire logic mainSupplyValid,
   input wire logic supplyGoodIn,
   input wire logic frontPanelResetN,
   // Outputs
   output logic powerButtonOutN,
   output logic resumeResetN,
   output logic mainPowerGood,
   output logic secondPowerGood
);
   // Registers
   logic [7:0] wakeCtl_q; // Wake control
   logic [7:0] pwIdx_q; // Password index
   logic [7:0] pgCtl_q; // Power-good delay control
   logic [7:0] pwMem_q [0:wake_power_pkg::PW_SETS-1][0:wake_power_pkg::PW_BYTES-1]; // Password bytes
   logic waitReq_q; // Bus wait
   logic [31:0] readData_q; // Bus read data
   // Sequencing state
   logic [15:0] tickCnt_q; // Millisecond divider
   logic msTick_q; // One-cycle tick
   logic pbOutN_q; // Button output, low while pulsing
   logic secondClick_q; // First of two clicks seen
   logic resumeN_q; // Resume reset output
   logic fpDelayed_q; // Delayed front-panel level
   logic pg_q; // Main power good
   logic pg2_q; // Second power good

   // Synchronised pins
   logic [3:0] pinSync;
   logic standbyOk, mainOk, supplyOk, fpLevel;
   sync2 #(.WIDTH(4)) pinSyncer (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .asyncIn({frontPanelResetN, supplyGoodIn, mainSupplyValid, standbySupplyValid}),
      .syncOut(pinSync)
   );
   assign standbyOk = pinSync[0];
   assign mainOk = pinSync[1];
   assign supplyOk = pinSync[2];
   assign fpLevel = pinSync[3];

   // Bus decode
   wire busReq = read | write;
   wire accept = busReq & ~waitReq_q;
   wire [7:0] regIdx = address[9:2];
   wire aligned = (address[1:0] == 2'b00);
   wire doWrite = write & accept & byteenable[0] & aligned;
   wire [3:0] pwSetNib = pwIdx_q[7:4];
   wire [3:0] pwPos = pwIdx_q[3:0];
   wire pwSetHit0 = (pwSetNib == wake_power_pkg::PW_SET0_BASE);
   wire pwSetHit1 = (pwSetNib == wake_power_pkg::PW_SET1_BASE);
   wire pwSetHit2 = (pwSetNib == wake_power_pkg::PW_SET2_BASE);
   wire [1:0] pwSet = pwSetHit2 ? 2'd2 : (pwSetHit1 ? 2'd1 : 2'd0);
   wire pwIdxOk = (pwSetHit0 | pwSetHit1 | pwSetHit2) & (pwPos != wake_power_pkg::PW_LAST_POS); // see R4
   wire [7:0] pwRead = pwIdxOk ? pwMem_q[pwSet][pwPos] : 8'h00;
   wire [7:0] statusByte = {2'b00, supplyOk, mainOk, standbyOk, ~pbOutN_q, pg_q, resumeN_q};
   wire [7:0] rdMux = !aligned ? 8'h00 :
      (regIdx == wake_power_pkg::WAKE_CTL_IDX) ? wakeCtl_q :
      (regIdx == wake_power_pkg::PW_INDEX_IDX) ? pwIdx_q :
      (regIdx == wake_power_pkg::PW_DATA_IDX) ? pwRead :
      (regIdx == wake_power_pkg::PG_CTL_IDX) ? pgCtl_q :
      (regIdx == wake_power_pkg::STATUS_IDX) ? statusByte : 8'h00;

   // Bus handshake: one wait cycle, then accept
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         waitReq_q <= 1'b1;
         readData_q <= 32'h00000000;
      end else begin
         waitReq_q <= ~(busReq & waitReq_q);
         if (read && waitReq_q) begin
            readData_q <= {24'h000000, rdMux};
         end
      end
   end

   // Control register writes
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         wakeCtl_q <= wake_power_pkg::WAKE_CTL_RESET;
         pwIdx_q <= wake_power_pkg::PW_INDEX_RESET;
         pgCtl_q <= wake_power_pkg::PG_CTL_RESET;
      end else if (doWrite) begin
         if (regIdx == wake_power_pkg::WAKE_CTL_IDX) begin
            wakeCtl_q <= writedata[7:0];
         end
         if (regIdx == wake_power_pkg::PW_INDEX_IDX) begin
            pwIdx_q <= writedata[7:0];
         end
         if (regIdx == wake_power_pkg::PG_CTL_IDX) begin
            pgCtl_q <= writedata[7:0];
         end
      end
   end

   // Password storage, written through the data register
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int s = 0; s < wake_power_pkg::PW_SETS; s++) begin
            for (int b = 0; b < wake_power_pkg::PW_BYTES; b++) begin
               pwMem_q[s][b] <= 8'h00;
            end
         end
      end else if (doWrite && regIdx == wake_power_pkg::PW_DATA_IDX && pwIdxOk) begin
         pwMem_q[pwSet][pwPos] <= writedata[7:0]; // see R4
      end
   end

   // Millisecond tick from the core clock
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         tickCnt_q <= 16'h0000;
         msTick_q <= 1'b0;
      end else if (tickCnt_q == 16'(TICK_CYCLES - 1)) begin
         tickCnt_q <= 16'h0000;
         msTick_q <= 1'b1; // see R18
      end else begin
         tickCnt_q <= tickCnt_q + 16'h0001;
         msTick_q <= 1'b0;
      end
   end

   // Keyboard wake terms
   wire kbdOn = wakeCtl_q[wake_power_pkg::KBD_EN_BIT];
   wire anyKeyMode = wakeCtl_q[wake_power_pkg::ANY_KEY_BIT];
   wire kbdAny = kbdOn & anyKeyMode & kbdByteValid; // see R2, R3
   wire [wake_power_pkg::PW_SETS-1:0] pwHit;
   wire pwByte = kbdOn & ~anyKeyMode & kbdByteValid;
   wire kbdPw = kbdOn & ~anyKeyMode & (|pwHit); // see R2, R3

   // Per-set sequence matchers over the stored key codes
   generate
      for (genvar s = 0; s < wake_power_pkg::PW_SETS; s++) begin : pwMatch
         logic [3:0] pos_q; // Next stored byte to match
         wire [7:0] wantByte = pwMem_q[s][pos_q];
         wire [7:0] first = pwMem_q[s][0];
         // Whole sequence seen up to a zero byte or the end of the set
         assign pwHit[s] = (pos_q != 4'h0) &&
            ((pos_q == wake_power_pkg::PW_LAST_POS) || (wantByte == 8'h00)); // see R5
         always_ff @(posedge core_clk or negedge reset_n) begin
            if (!reset_n) begin
               pos_q <= 4'h0;
            end else if (kbdPw || !kbdOn || anyKeyMode) begin
               pos_q <= 4'h0;
            end else if (pwByte) begin
               // Make, break prefix and make each compared in turn
               if (kbdByte == wantByte) begin
                  pos_q <= pos_q + 4'h1; // see R5
               end else if (kbdByte == first && first != 8'h00) begin
                  pos_q <= 4'h1;
               end else begin
                  pos_q <= 4'h0;
               end
            end
         end
      end
   endgenerate

   // Mouse wake selection
   wire mouseOn = wakeCtl_q[wake_power_pkg::MOUSE_EN_BIT]; // see R7
   wire selMove = pgCtl_q[wake_power_pkg::MOUSE_MOVE_BIT];
   wire selRight = wakeCtl_q[wake_power_pkg::MOUSE_RIGHT_BIT];
   wire selDouble = wakeCtl_q[wake_power_pkg::MOUSE_DOUBLE_BIT];
   wire [2:0] mouseSel = {selMove, selRight, selDouble};
   wire targetClick = selRight ? mouseRightClick : mouseLeftClick;
   wire otherClick = selRight ? mouseLeftClick : mouseRightClick;
   wire doubleMode = ~selMove & ~selDouble;
   wire mouseSingle = (selMove & selRight) ? (mouseLeftClick | mouseRightClick | mouseMove) :
      (mouseSel == 3'b011) ? (mouseLeftClick | mouseRightClick) :
      (mouseSel == 3'b001) ? mouseLeftClick :
      (mouseSel == 3'b101) ? mouseRightClick : 1'b0; // see R8
   wire mouseDouble = doubleMode & targetClick & secondClick_q; // see R9
   wire mouseWake = mouseOn & (mouseSingle | mouseDouble);
   wire wakeStart = pbOutN_q & ((kbdAny | kbdPw) | mouseWake); // see R1

   // Click counter for the two-click events
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         secondClick_q <= 1'b0;
      end else if (!mouseOn || !doubleMode || otherClick) begin
         secondClick_q <= 1'b0;
      end else if (targetClick) begin
         secondClick_q <= ~secondClick_q; // see R9
      end
   end

   // Wake pulse timer
   logic pulseDone;
   ms_delay pulseTimer (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .msTick(msTick_q),
      .start(~pbOutN_q),
      .limit(PULSE_MS),
      .done(pulseDone)
   );

   // One low pulse per accepted event; events during a pulse are dropped
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pbOutN_q <= 1'b1;
      end else if (wakeStart) begin
         pbOutN_q <= 1'b0; // see R1, R19
      end else if (pulseDone) begin
         pbOutN_q <= 1'b1; // see R19
      end
   end

   // Resume reset delay after standby becomes valid
   logic resumeDone;
   ms_delay resumeTimer (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .msTick(msTick_q),
      .start(standbyOk),
      .limit(wake_power_pkg::RESUME_DELAY_MS),
      .done(resumeDone)
   );

   // Power-good stage one, then stage two
   logic stageOneDone, stageTwoDone, fpDone;
   wire [9:0] stageOneMs = pgCtl_q[wake_power_pkg::PG_SHORT_BIT] ?
      wake_power_pkg::PG_SHORT_MS : wake_power_pkg::PG_LONG_MS; // see R12, R14
   wire [1:0] stageSel = pgCtl_q[wake_power_pkg::PG_STAGE_LSB +: 2];
   wire [9:0] stageTwoMs = (stageSel == 2'b00) ? wake_power_pkg::PG_EXTRA0_MS :
      (stageSel == 2'b01) ? wake_power_pkg::PG_EXTRA1_MS :
      (stageSel == 2'b10) ? wake_power_pkg::PG_EXTRA2_MS : wake_power_pkg::PG_EXTRA3_MS; // see R15
   ms_delay stageOneTimer (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .msTick(msTick_q),
      .start(mainOk),
      .limit(stageOneMs),
      .done(stageOneDone)
   );
   ms_delay stageTwoTimer (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .msTick(msTick_q),
      .start(stageOneDone),
      .limit(stageTwoMs),
      .done(stageTwoDone)
   );
   // Front-panel level is copied once it has held steady long enough
   ms_delay frontTimer (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .msTick(msTick_q),
      .start(fpLevel != fpDelayed_q),
      .limit(wake_power_pkg::FRONT_DELAY_MS),
      .done(fpDone)
   );
   wire pgNext = mainOk & supplyOk & stageTwoDone & fpDelayed_q; // see R17

   // Output flops for resets and power goods
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         resumeN_q <= 1'b0;
         fpDelayed_q <= 1'b0;
         pg_q <= 1'b0;
         pg2_q <= 1'b0;
      end else begin
         resumeN_q <= standbyOk & resumeDone; // see R10, R11
         if (fpDone) begin
            fpDelayed_q <= fpLevel; // see R16
         end
         pg_q <= pgNext; // see R13, R16
         pg2_q <= pgNext;
      end
   end

   assign readdata = readData_q;
   assign waitrequest = waitReq_q;
   assign powerButtonOutN = pbOutN_q;
   assign resumeResetN = resumeN_q;
   assign mainPowerGood = pg_q;
   assign secondPowerGood = pg2_q;

   // Ticks seen during a wake pulse, for checking its length
   logic [9:0] pulseTicks_q;
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pulseTicks_q <= 10'h000;
      end else if (wakeStart) begin
         pulseTicks_q <= 10'h000;
      end else if (!pbOutN_q && msTick_q) begin
         pulseTicks_q <= pulseTicks_q + 10'h001;
      end
   end

   sequence startSeen_s;
      wakeStart;
   endsequence
   sequence pulseLow_s;
      !powerButtonOutN [*2];
   endsequence

   wakePulseStart_a: assert property (@(posedge core_clk) disable iff (!reset_n) startSeen_s |=> pulseLow_s) // see R1
      else $error("wake event did not pull button output low");
   kbdDisabled_a: assert property (@(posedge core_clk) disable iff (!reset_n) !kbdOn |-> !(kbdAny | kbdPw)) // see R2
      else $error("keyboard wake while disabled");
   anyKeyWake_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      (kbdOn && anyKeyMode && kbdByteValid && powerButtonOutN) |=> !powerButtonOutN) // see R3
      else $error("any key did not wake");
   mouseDisabled_a: assert property (@(posedge core_clk) disable iff (!reset_n) !mouseOn |-> !mouseWake) // see R7
      else $error("mouse wake while disabled");
   pulseLength_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      $rose(powerButtonOutN) |-> pulseTicks_q == PULSE_MS) // see R19
      else $error("wake pulse length wrong");
   resumeDrop_a: assert property (@(posedge core_clk) disable iff (!reset_n) !standbyOk |=> !resumeResetN) // see R11
      else $error("resume reset not dropped at once");
   resumeRise_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      $rose(resumeResetN) |-> $past(resumeDone) && $past(standbyOk)) // see R10
      else $error("resume reset rose before delay");
   powerDrop_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      (!mainOk || !supplyOk) |=> !mainPowerGood && !secondPowerGood) // see R13, R17
      else $error("power good not dropped at once");
   powerRise_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      $rose(mainPowerGood) |-> $past(stageTwoDone) && $past(fpDelayed_q)) // see R12, R15
      else $error("power good rose before delay");
   goodsEqual_a: assert property (@(posedge core_clk) disable iff (!reset_n) mainPowerGood == secondPowerGood) // see R16
      else $error("power good outputs differ");
   busAnswer_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      (busReq && waitrequest) |=> !waitrequest ##1 waitrequest)
      else $error("bus answer not one cycle");
endmodule

// File: shared/wake_power_pkg.sv
// Constants shared by the wake and power-good sequencer
// Summary of operation
// R1 - Matching key or mouse event pulses button output low
// R2 - Keyboard wake works only with control bit 6
// R3 - Control bit 0: any key, else password
// R4 - Three password sets reached through index/data registers
// R5 - Each key is make, break prefix, make
// R6 - Software zero-fills unused password bytes
// R7 - Mouse wake works only with control bit 5
// R8 - Three select bits choose single mouse event
// R9 - Patterns 000/010 need two left/right clicks
// R10 - Resume reset rises 100-200 ms after standby valid
// R11 - Resume reset drops at once on standby loss
// R12 - Power good rises 300-500 ms after main valid
// R13 - Power good drops at once on main loss
// R14 - Delay bit 3 shortens first stage to 200-300
// R15 - Bits 2:1 add 0/32/96/250 ms second stage
// R16 - Both power goods follow front reset after 28-39ms
// R17 - Power good needs supply good; drops without it
// R18 - Delays count ms ticks, restart on lost start
// R19 - One fixed-length wake pulse per event
package wake_power_pkg;
   // Clock and time base
   localparam int CLK_PERIOD_NS = 50;
   localparam int MS_IN_NS = 1000000;
   localparam int TICK_CYCLES = MS_IN_NS / CLK_PERIOD_NS;

   // Register indices; byte address is four times the index
   localparam logic [7:0] WAKE_CTL_IDX = 8'hE0;
   localparam logic [7:0] PW_INDEX_IDX = 8'hE1;
   localparam logic [7:0] PW_DATA_IDX = 8'hE2;
   localparam logic [7:0] PG_CTL_IDX = 8'hE6;
   localparam logic [7:0] STATUS_IDX = 8'hE8;

   // Reset values
   localparam logic [7:0] WAKE_CTL_RESET = 8'h01;
   localparam logic [7:0] PW_INDEX_RESET = 8'h00;
   localparam logic [7:0] PG_CTL_RESET = 8'h00;

   // Wake control fields
   localparam int KBD_EN_BIT = 6;
   localparam int MOUSE_EN_BIT = 5;
   localparam int MOUSE_RIGHT_BIT = 4;
   localparam int MOUSE_DOUBLE_BIT = 1;
   localparam int ANY_KEY_BIT = 0;

   // Power-good delay control fields
   localparam int MOUSE_MOVE_BIT = 7;
   localparam int PG_SHORT_BIT = 3;
   localparam int PG_STAGE_LSB = 1;

   // Password storage layout: upper index nibble picks the set
   localparam int PW_SETS = 3;
   localparam int PW_BYTES = 15;
   localparam logic [3:0] PW_SET0_BASE = 4'h0;
   localparam logic [3:0] PW_SET1_BASE = 4'h3;
   localparam logic [3:0] PW_SET2_BASE = 4'h4;
   localparam logic [3:0] PW_LAST_POS = 4'hF;

   // Delays in milliseconds
   localparam logic [9:0] RESUME_DELAY_MS = 10'd150;
   localparam logic [9:0] PG_LONG_MS = 10'd400;
   localparam logic [9:0] PG_SHORT_MS = 10'd250;
   localparam logic [9:0] PG_EXTRA0_MS = 10'd0;
   localparam logic [9:0] PG_EXTRA1_MS = 10'd32;
   localparam logic [9:0] PG_EXTRA2_MS = 10'd96;
   localparam logic [9:0] PG_EXTRA3_MS = 10'd250;
   localparam logic [9:0] FRONT_DELAY_MS = 10'd33;
   localparam logic [9:0] WAKE_PULSE_MS = 10'd100;

   // Status register fields
   localparam int ST_RESUME_BIT = 0;
   localparam int ST_POWER_BIT = 1;
   localparam int ST_PULSE_BIT = 2;
   localparam int ST_STANDBY_BIT = 3;
   localparam int ST_MAIN_BIT = 4;
   localparam int ST_SUPPLY_BIT = 5;
endpackage

// File: verif/button_observer.sv
// Far-side model that watches the wake pulses on the power-button line
`timescale 1ns/100ps
module button_observer (
   input wire logic core_clk,
   input wire logic powerButtonOutN,
   output int pulses,
   output int width
);
   int runLen; // Low cycles seen in the current pulse
   // Count finished low pulses and keep the length of the last one
   initial begin
      pulses = 0;
      width = 0;
      runLen = 0;
      forever begin
         @(posedge core_clk);
         if (powerButtonOutN === 1'b0) begin
            runLen++;
         end else if (runLen > 0) begin
            pulses++;
            width = runLen;
            runLen = 0;
         end
      end
   end
endmodule

// File: verif/wake_and_power_good_sequencer_tb.sv
// Self-checking bench for the wake and power-good sequencer
`timescale 1ns/100ps
module wake_and_power_good_sequencer_tb;
   localparam int TK = 4; // Cycles per ms tick, shortened
   localparam logic [9:0] PMS = 10'h003; // Shortened wake pulse
   logic core_clk, reset_n, read, write, waitrequest, kbdByteValid;
   logic mouseLeftClick, mouseRightClick, mouseMove, standbySupplyValid;
   logic mainSupplyValid, supplyGoodIn, frontPanelResetN, powerButtonOutN;
   logic resumeResetN, mainPowerGood, secondPowerGood;
   logic [9:0] address;
   logic [31:0] writedata, readdata;
   logic [3:0] byteenable;
   logic [7:0] kbdByte, rd;
   int nErrors, cmpCount, pulses, width, n, base;
   logic [11:0] mcase [12] = '{12'h6C0, 12'hEC1, 12'hB41, 12'hBC0, 12'h941, 12'h980,
      12'hD81, 12'hD40, 12'hCC0, 12'h868, 12'h895, 12'hA69};

   wake_and_power_good_sequencer #(.TICK_CYCLES(TK), .PULSE_MS(PMS)) i_dut (.core_clk(core_clk),
      .reset_n(reset_n), .address(address), .read(read), .write(write), .writedata(writedata),
      .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest), .kbdByte(kbdByte),
      .kbdByteValid(kbdByteValid), .mouseLeftClick(mouseLeftClick), .mouseRightClick(mouseRightClick),
      .mouseMove(mouseMove), .standbySupplyValid(standbySupplyValid), .mainSupplyValid(mainSupplyValid),
      .supplyGoodIn(supplyGoodIn), .frontPanelResetN(frontPanelResetN), .powerButtonOutN(powerButtonOutN),
      .resumeResetN(resumeResetN), .mainPowerGood(mainPowerGood), .secondPowerGood(secondPowerGood));
   button_observer i_obs (.core_clk(core_clk), .powerButtonOutN(powerButtonOutN), .pulses(pulses),
      .width(width));

   // Verdict and end of run
   task automatic completeRun();
      if (nErrors == 0 && cmpCount > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Exact compare
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmpCount++;
      if (got !== exp) begin
         $display("[ERR] %s expected %0h seen %0h", what, exp, got);
         nErrors++;
      end
   endtask

   // Window compare on cycle counts
   task automatic chkIn(input string what, input int lo, input int hi, input int got);
      cmpCount++;
      if (got < lo || got > hi) begin
         $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
         nErrors++;
      end
   endtask

   // One Avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      int k;
      k = 0;
      @(posedge core_clk);
      address <= {idx, 2'b00};
      write <= wr;
      read <= ~wr;
      writedata <= {24'h000000, wd};
      @(posedge core_clk);
      while (waitrequest !== 1'b0 && k < 20) begin
         @(posedge core_clk);
         k++;
      end
      rd = readdata[7:0];
      write <= 1'b0;
      read <= 1'b0;
      if (k >= 20) begin
         chk("bus wait", 0, 1);
         completeRun();
      end
   endtask

   // Read one register and compare
   task automatic rdChk(input string what, input logic [7:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00);
      chk(what, exp, rd);
   endtask

   // Bounded wait for an output level; sel 0 resume, 1 power good
   task automatic waitFor(input int sel, input logic lvl, input int maxC);
      n = 0;
      while (((sel == 0) ? resumeResetN : mainPowerGood) !== lvl && n < maxC) begin
         @(posedge core_clk);
         n++;
      end
      if (n >= maxC) begin
         chk("level wait", 0, 1);
         completeRun();
      end
   endtask

   // One-cycle event pulse: 1 left, 2 right, 3 move, 4 key byte b
   task automatic ev(input int k, input logic [7:0] b);
      @(posedge core_clk);
      mouseLeftClick <= (k == 1);
      mouseRightClick <= (k == 2);
      mouseMove <= (k == 3);
      kbdByteValid <= (k == 4);
      kbdByte <= b;
      @(posedge core_clk);
      {mouseLeftClick, mouseRightClick, mouseMove, kbdByteValid} <= 4'h0;
      @(posedge core_clk);
   endtask

   // Let any pulse finish, then count pulses since base
   task automatic settle(input string what, input int exp);
      repeat (PMS * TK + 20) @(posedge core_clk);
      chk(what, exp, pulses - base);
      if (pulses > base) chkIn("pulse width", PMS * TK - TK, PMS * TK + TK + 3, width);
      base = pulses;
   endtask

   // Reset values, read-back, unmapped place
   task automatic regsTest();
      rdChk("wake_control", 8'hE0, 8'h01);
      rdChk("password_index", 8'hE1, 8'h00);
      rdChk("pg_delay_control", 8'hE6, 8'h00);
      bus(1'b1, 8'hE6, 8'h8E);
      rdChk("pg_delay_control rw", 8'hE6, 8'h8E);
      rdChk("unmapped", 8'hE3, 8'h00);
      byteenable <= 4'h0;
      bus(1'b1, 8'hE1, 8'h55);
      byteenable <= 4'hF;
      rdChk("masked write", 8'hE1, 8'h00);
   endtask

   // Keyboard enable and any-key wake, second key during the pulse dropped
   task automatic keyTest();
      bus(1'b1, 8'hE0, 8'h01);
      ev(4, 8'h1C);
      settle("kbd disabled", 0);
      bus(1'b1, 8'hE0, 8'h41);
      ev(4, 8'h1C);
      ev(4, 8'h2A);
      settle("any key", 1);
   endtask

   // Password set 0 holds make, break prefix, make; rest zero-filled
   task automatic passwordTest();
      bus(1'b1, 8'hE0, 8'h40);
      for (int i = 0; i < 15; i++) begin
         bus(1'b1, 8'hE1, i[7:0]);
         bus(1'b1, 8'hE2, (i == 1) ? 8'hF0 : ((i == 0 || i == 2) ? 8'h45 : 8'h00));
      end
      bus(1'b1, 8'hE1, 8'h01);
      rdChk("password byte", 8'hE2, 8'hF0);
      bus(1'b1, 8'hE1, 8'h3E);
      bus(1'b1, 8'hE2, 8'h5A);
      rdChk("password set1", 8'hE2, 8'h5A);
      bus(1'b1, 8'hE1, 8'h0F);
      rdChk("password bad index", 8'hE2, 8'h00);
      ev(4, 8'h16);
      ev(4, 8'hF0);
      ev(4, 8'h16);
      settle("wrong password", 0);
      ev(4, 8'h45);
      ev(4, 8'hF0);
      ev(4, 8'h45);
      settle("password", 1);
   endtask

   // Seven mouse select patterns (all but 111), one of them with mouse wake disabled
   task automatic mouseTest();
      foreach (mcase[i]) begin
         bus(1'b1, 8'hE0, {2'b00, mcase[i][11], mcase[i][9], 2'b00, mcase[i][8], 1'b0});
         bus(1'b1, 8'hE6, {mcase[i][10], 7'h00});
         ev(mcase[i][7:6], 8'h00);
         ev(mcase[i][5:4], 8'h00);
         ev(mcase[i][3:2], 8'h00);
         settle("mouse case", {31'h00000000, mcase[i][0]});
      end
   endtask

   // Resume reset delay, restart on a lost start, immediate drop
   task automatic resumeTest();
      standbySupplyValid <= 1'b1;
      repeat (50 * TK) @(posedge core_clk);
      chk("resume early", 0, resumeResetN);
      standbySupplyValid <= 1'b0;
      repeat (4) @(posedge core_clk);
      standbySupplyValid <= 1'b1;
      waitFor(0, 1'b1, 1000);
      chkIn("resume delay", 100 * TK, 200 * TK, n);
      standbySupplyValid <= 1'b0;
      waitFor(0, 1'b0, 6);
      standbySupplyValid <= 1'b1;
   endtask

   // Two-stage power-good delay for each stage code, short first stage with codes 01 and 11
   task automatic powerTest();
      supplyGoodIn <= 1'b1;
      for (int c = 0; c < 4; c++) begin
         bus(1'b1, 8'hE6, {4'h0, c[0], c[1:0], 1'b0});
         mainSupplyValid <= 1'b1;
         waitFor(1, 1'b1, 3000);
         chkIn("pg delay", (c[0] ? 200 : 300) * TK + (c == 1 ? 32 : c == 2 ? 96 : c == 3 ? 250 : 0) * TK,
            (c[0] ? 300 : 500) * TK + (c == 1 ? 32 : c == 2 ? 96 : c == 3 ? 250 : 0) * TK + 6, n);
         chk("second pg", 1, secondPowerGood);
         mainSupplyValid <= 1'b0;
         waitFor(1, 1'b0, 6);
      end
      supplyGoodIn <= 1'b0;
      mainSupplyValid <= 1'b1;
      repeat (2700 * TK / 4) @(posedge core_clk);
      chk("pg without supply good", 0, mainPowerGood);
      supplyGoodIn <= 1'b1;
      waitFor(1, 1'b1, 6);
      supplyGoodIn <= 1'b0;
      waitFor(1, 1'b0, 6);
      supplyGoodIn <= 1'b1;
      waitFor(1, 1'b1, 6);
   endtask

   // Front-panel low then high is copied to both power goods, delayed
   task automatic frontTest();
      frontPanelResetN <= 1'b0;
      waitFor(1, 1'b0, 200);
      chkIn("front fall", 28 * TK, 39 * TK + 4, n);
      chk("second pg low", 0, secondPowerGood);
      repeat (40 * TK - n) @(posedge core_clk);
      frontPanelResetN <= 1'b1;
      waitFor(1, 1'b1, 200);
      chkIn("front rise", 28 * TK, 39 * TK + 4, n);
      chk("second pg high", 1, secondPowerGood);
   endtask

   // Clock
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   // Main sequence
   initial begin
      {reset_n, read, write, kbdByteValid, mouseLeftClick, mouseRightClick, mouseMove} = 7'h00;
      {standbySupplyValid, mainSupplyValid, supplyGoodIn} = 3'h0;
      frontPanelResetN = 1'b1;
      address = 10'h000;
      writedata = 32'h00000000;
      byteenable = 4'hF;
      kbdByte = 8'h00;
      nErrors = 0;
      cmpCount = 0;
      repeat (10) @(posedge core_clk);
      reset_n <= 1'b1;
      base = pulses;
      regsTest();
      keyTest();
      passwordTest();
      mouseTest();
      resumeTest();
      powerTest();
      frontTest();
      completeRun();
   end
endmodule
